// [hdl/vps_pkg.sv]
`default_nettype none
package vps_pkg;
  // Parameter bus geometry
  localparam int         ADDR_W        = 5;
  localparam int         DATA_W        = 32;
  localparam int         PARAM_W       = 16;
  // Register byte offsets
  localparam logic [4:0] OFS_WIDTH     = 5'h00;
  localparam logic [4:0] OFS_HEIGHT    = 5'h04;
  localparam logic [4:0] OFS_FIELD     = 5'h08;
  localparam logic [4:0] OFS_BYPASS    = 5'h0c;
  localparam logic [4:0] OFS_KEEP      = 5'h10;
  localparam logic [4:0] OFS_STILL_TH  = 5'h14;
  localparam logic [4:0] OFS_SLOW_TH   = 5'h18;
  localparam logic [4:0] OFS_UPDATE    = 5'h1c;
  // Single-bit fields sit in bit 0
  localparam int         FLAG_BIT      = 0;
  // Generation-time frame limits and field/threshold defaults
  localparam int         MAX_WIDTH     = 1920;
  localparam int         MAX_HEIGHT    = 1080;
  localparam int         MIN_DIM_M1    = 63;
  localparam logic [15:0] RST_WIDTH    = 16'(MAX_WIDTH - 1);
  localparam logic [15:0] RST_HEIGHT   = 16'(MAX_HEIGHT - 1);
  localparam logic [15:0] RST_FIELD    = 16'h0000;
  localparam logic [15:0] RST_BYPASS   = 16'h0000;
  localparam logic [15:0] RST_KEEP     = 16'h0000;
  localparam logic [15:0] RST_STILL_TH = 16'h0100;
  localparam logic [15:0] RST_SLOW_TH  = 16'h0400;
  localparam logic        RST_UPDATE   = 1'b0;
  // Memory layout options fixed at generation
  localparam int         PIX_BITS      = 16;
  localparam int         MEM_DATA_W    = 32;
  localparam int         BURST_LEN     = 8;
  localparam int         BURST_CNT     = 1;
  localparam int         BURST_BITS    = (BURST_LEN * BURST_CNT / 2) * MEM_DATA_W;
  localparam bit         INTER_ALGO    = 1'b1;
  localparam bit         FRC_EN        = 1'b0;
  localparam int         BASE_FRAMES   = 2;
  localparam logic [2:0] FRAME_SPACES  = 3'(BASE_FRAMES + int'(INTER_ALGO) + int'(FRC_EN));
endpackage : vps_pkg
`default_nettype wire

// [hdl/vps_shadow_reg.sv]
`timescale 1ns/100ps
`default_nettype none
// One double-buffered parameter: host side shadow plus working copy
module vps_shadow_reg #(
  parameter int               W     = 16,
  parameter logic [W-1:0]     RST   = '0
) (
  input  wire logic           sys_clk,
  input  wire logic           reset_n,
  input  wire logic           wr_en,
  input  wire logic [W-1:0]   wdata,
  input  wire logic           load,
  output logic      [W-1:0]   shadow_q,
  output logic      [W-1:0]   work_q
);
  // Shadow takes host writes; working copy only moves on a load
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      shadow_q <= RST;
      work_q   <= RST;
    end else begin
      if (wr_en) shadow_q <= wdata;
      if (load)  work_q   <= shadow_q;
    end
  end
endmodule // vps_shadow_reg
`default_nettype wire

// [hdl/vps_line_bursts.sv]
`timescale 1ns/100ps
`default_nettype none
// Splits one video line into memory bursts and checks the burst fits a line
module vps_line_bursts (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] width_m1,
  output logic      [15:0] bursts_per_line,
  output logic             burst_fits_line
);
  localparam logic [31:0] BURST_BITS = 32'(vps_pkg::BURST_BITS);
  localparam logic [31:0] PIX_BITS   = 32'(vps_pkg::PIX_BITS);

  wire logic [31:0] line_bits = (32'(width_m1) + 32'h1) * PIX_BITS;
  // Divisor is a constant, so this folds to shifts for power-of-two bursts
  wire logic [31:0] n_bursts  = (line_bits + BURST_BITS - 32'h1) / BURST_BITS;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bursts_per_line <= 16'h0000;
      burst_fits_line <= 1'b0;
    end else begin
      bursts_per_line <= n_bursts[15:0];
      burst_fits_line <= (BURST_BITS <= line_bits);
    end
  end
endmodule // vps_line_bursts
`default_nettype wire

// [hdl/vps_regs.sv]
// Behaviour
// - Writes go to shadow registers; working copies change only at commit points.
// - First field 0 means top first, 1 bottom first; generation default.
// - Bypass 1 passes interlaced video unchanged; 0 processes; resets to 0.
// - Keep 1 locks: repeat frame with rate conversion, else no output.
// - Still threshold, up to 65535, bounds still pixels for inter algorithm.
// - Host sets update flag; device clears it after loading working registers.
// - Keep and both thresholds take effect at next frame start regardless.
// - With update set, size, field and bypass load at input frame start.
// - Lines move to memory as several burst transactions.
// - One burst must not exceed one video line.
// - Weave, bob, intra use two frame spaces, three with rate conversion.
// - Inter uses three frame spaces, four with rate conversion.
// - Bus has high write strobe, 5-bit address, read and write data.
`timescale 1ns/100ps
`default_nettype none
module vps_regs (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        param_write,
  input  wire logic [4:0]  param_addr,
  input  wire logic [31:0] param_wdata,
  output logic      [31:0] param_rdata,
  input  wire logic        frame_start,
  output logic      [15:0] work_width_m1,
  output logic      [15:0] work_height_m1,
  output logic             work_first_field,
  output logic             work_bypass,
  output logic             work_keep,
  output logic      [15:0] work_still_th,
  output logic      [15:0] work_slow_th,
  output logic             repeat_frame,
  output logic             suppress_frames,
  output logic             update_pending,
  output logic      [15:0] bursts_per_line,
  output logic             burst_fits_line,
  output logic      [2:0]  frame_spaces
);
  // Rate conversion option, used by the lock checks below
  localparam bit FRC_ON = vps_pkg::FRC_EN;

  // Update flag register
  logic update_flag;

  // Shadow copies, read back by the host, then the 1-bit working copies
  logic [15:0] sh_width;
  logic [15:0] sh_height;
  logic [0:0]  sh_field;
  logic [0:0]  sh_bypass;
  logic [0:0]  sh_keep;
  logic [15:0] sh_still;
  logic [15:0] sh_slow;
  logic [0:0]  wk_field;
  logic [0:0]  wk_bypass;
  logic [0:0]  wk_keep;

  // Address hits, shared by the write decode and the read mux
  wire logic hit_width  = (param_addr == vps_pkg::OFS_WIDTH);
  wire logic hit_height = (param_addr == vps_pkg::OFS_HEIGHT);
  wire logic hit_field  = (param_addr == vps_pkg::OFS_FIELD);
  wire logic hit_bypass = (param_addr == vps_pkg::OFS_BYPASS);
  wire logic hit_keep   = (param_addr == vps_pkg::OFS_KEEP);
  wire logic hit_still  = (param_addr == vps_pkg::OFS_STILL_TH);
  wire logic hit_slow   = (param_addr == vps_pkg::OFS_SLOW_TH);
  wire logic hit_update = (param_addr == vps_pkg::OFS_UPDATE);

  // Write decode; parameter writes are shut out while a commit is pending
  wire logic open_wr   = param_write && !update_flag;
  wire logic wr_width  = open_wr && hit_width;
  wire logic wr_height = open_wr && hit_height;
  wire logic wr_field  = open_wr && hit_field;
  wire logic wr_bypass = open_wr && hit_bypass;
  wire logic wr_keep   = open_wr && hit_keep;
  wire logic wr_still  = open_wr && hit_still;
  wire logic wr_slow   = open_wr && hit_slow;
  wire logic wr_update = open_wr && hit_update;

  // Commit points: frame geometry waits for update, per-frame values do not.
  // A frame in flight keeps its working copy, so a host write never tears it
  wire logic commit    = frame_start && update_flag;
  wire logic frame_ld  = frame_start;

  // Flags keep only bit 0; wide values keep the low 16 bits
  wire logic [15:0] wd16 = param_wdata[15:0];
  wire logic        wd1  = param_wdata[vps_pkg::FLAG_BIT];

  vps_shadow_reg #(.W(16), .RST(vps_pkg::RST_WIDTH)) u_width (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .wr_en    (wr_width),
    .wdata    (wd16),
    .load     (commit),
    .shadow_q (sh_width),
    .work_q   (work_width_m1)
  );

  vps_shadow_reg #(.W(16), .RST(vps_pkg::RST_HEIGHT)) u_height (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .wr_en    (wr_height),
    .wdata    (wd16),
    .load     (commit),
    .shadow_q (sh_height),
    .work_q   (work_height_m1)
  );

  vps_shadow_reg #(.W(1), .RST(vps_pkg::RST_FIELD[0])) u_field (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .wr_en    (wr_field),
    .wdata    (wd1),
    .load     (commit),
    .shadow_q (sh_field),
    .work_q   (wk_field)
  );

  vps_shadow_reg #(.W(1), .RST(vps_pkg::RST_BYPASS[0])) u_bypass (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .wr_en    (wr_bypass),
    .wdata    (wd1),
    .load     (commit),
    .shadow_q (sh_bypass),
    .work_q   (wk_bypass)
  );

  vps_shadow_reg #(.W(1), .RST(vps_pkg::RST_KEEP[0])) u_keep (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .wr_en    (wr_keep),
    .wdata    (wd1),
    .load     (frame_ld),
    .shadow_q (sh_keep),
    .work_q   (wk_keep)
  );

  vps_shadow_reg #(.W(16), .RST(vps_pkg::RST_STILL_TH)) u_still (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .wr_en    (wr_still),
    .wdata    (wd16),
    .load     (frame_ld),
    .shadow_q (sh_still),
    .work_q   (work_still_th)
  );

  vps_shadow_reg #(.W(16), .RST(vps_pkg::RST_SLOW_TH)) u_slow (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .wr_en    (wr_slow),
    .wdata    (wd16),
    .load     (frame_ld),
    .shadow_q (sh_slow),
    .work_q   (work_slow_th)
  );

  // Working flags as plain levels for the datapath
  assign work_first_field = wk_field[0];
  assign work_bypass      = wk_bypass[0];
  assign work_keep        = wk_keep[0];
  assign update_pending   = update_flag;

  // Frame memory sized by algorithm and rate conversion
  assign frame_spaces = vps_pkg::FRAME_SPACES;

  // Lock behaviour follows the rate conversion option
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      repeat_frame    <= 1'b0;
      suppress_frames <= 1'b0;
    end else if (frame_ld) begin
      repeat_frame    <= sh_keep[0] && vps_pkg::FRC_EN;
      suppress_frames <= sh_keep[0] && !vps_pkg::FRC_EN;
    end
  end

  // Update flag: host sets, commit clears; no collision since writes are
  // refused while the flag is up and a commit needs the flag up
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      update_flag <= vps_pkg::RST_UPDATE;
    end else if (commit) begin
      update_flag <= 1'b0;
    end else if (wr_update) begin
      update_flag <= param_wdata[vps_pkg::FLAG_BIT];
    end
  end

  // Read mux: shadow contents, zero upper bits, zero for holes
  wire logic [15:0] rd_sel =
    hit_width  ? sh_width                 :
    hit_height ? sh_height                :
    hit_field  ? {15'h0000, sh_field}     :
    hit_bypass ? {15'h0000, sh_bypass}    :
    hit_keep   ? {15'h0000, sh_keep}      :
    hit_still  ? sh_still                 :
    hit_slow   ? sh_slow                  :
    hit_update ? {15'h0000, update_flag}  :
                 16'h0000;

  // Registered read data, one cycle behind the address
  always_ff @(posedge sys_clk) begin
    if (!reset_n) param_rdata <= 32'h0000_0000;
    else          param_rdata <= {16'h0000, rd_sel};
  end

  // Burst split of the current working line
  vps_line_bursts u_bursts (
    .sys_clk         (sys_clk),
    .reset_n         (reset_n),
    .width_m1        (work_width_m1),
    .bursts_per_line (bursts_per_line),
    .burst_fits_line (burst_fits_line)
  );

  // Checks
  chk_commit_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
    frame_start && update_flag |=> !update_flag)
    else $error("update flag not cleared after commit");

  chk_update_sets: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_update && param_wdata[vps_pkg::FLAG_BIT] |=> update_flag)
    else $error("update flag not set by host write");

  chk_commit_size: assert property (@(posedge sys_clk) disable iff (!reset_n)
    commit |=> work_width_m1 == $past(sh_width) && work_height_m1 == $past(sh_height))
    else $error("frame size not committed");

  chk_hold_size: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !commit |=> $stable(work_width_m1) && $stable(work_height_m1))
    else $error("working size moved without commit");

  chk_field_bypass: assert property (@(posedge sys_clk) disable iff (!reset_n)
    commit |=> work_first_field == $past(sh_field[0]) && work_bypass == $past(sh_bypass[0]))
    else $error("field or bypass not committed");

  chk_bypass_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !commit |=> $stable(work_bypass) && $stable(work_first_field))
    else $error("bypass moved without commit");

  chk_frame_params: assert property (@(posedge sys_clk) disable iff (!reset_n)
    frame_start |=> work_keep == $past(sh_keep[0]) && work_slow_th == $past(sh_slow))
    else $error("keep or slow threshold not applied at frame");

  chk_still_th: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !frame_start |=> $stable(work_still_th))
    else $error("still threshold moved mid frame");

  chk_keep_mode: assert property (@(posedge sys_clk) disable iff (!reset_n)
    frame_start ##1 !frame_start |-> repeat_frame == (work_keep && FRC_ON)
      && suppress_frames == (work_keep && !FRC_ON))
    else $error("lock mode disagrees with keep");

  chk_write_blocked: assert property (@(posedge sys_clk) disable iff (!reset_n)
    update_flag && param_write |=> $stable(sh_width) && $stable(sh_keep))
    else $error("shadow written while commit pending");

  chk_read_hole: assert property (@(posedge sys_clk) disable iff (!reset_n)
    param_addr[1:0] != 2'b00 |=> param_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  chk_still_frame: assert property (@(posedge sys_clk) disable iff (!reset_n)
    frame_start |=> work_still_th == $past(sh_still))
    else $error("still threshold not applied at frame");

  chk_hold_frame: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !frame_start |=> $stable(work_keep) && $stable(work_slow_th))
    else $error("keep or slow threshold moved mid frame");

  chk_lock_excl: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(repeat_frame && suppress_frames))
    else $error("repeat and suppress both active");

  chk_refuse_rest: assert property (@(posedge sys_clk) disable iff (!reset_n)
    update_flag && param_write |=> $stable(sh_height) && $stable(sh_field)
      && $stable(sh_bypass) && $stable(sh_still) && $stable(sh_slow))
    else $error("other shadow written while commit pending");

  chk_flag_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    update_flag && !frame_start |=> update_flag)
    else $error("update flag dropped without frame start");

  chk_flag_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !update_flag && !wr_update |=> !update_flag)
    else $error("update flag rose without host write");

  // Sampled reset in the antecedent skips the edge that releases reset
  chk_read_width: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reset_n && hit_width |=> param_rdata == {16'h0000, $past(sh_width)})
    else $error("width read back wrong");

  chk_read_bypass: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reset_n && hit_bypass |=> param_rdata == {31'h0000_0000, $past(sh_bypass)})
    else $error("bypass read back wrong");

  chk_read_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reset_n && hit_update |=> param_rdata == {31'h0000_0000, $past(update_flag)})
    else $error("update flag read back wrong");
endmodule // vps_regs
`default_nettype wire

// [dv/vps_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Host side of the parameter bus; every change lands just after a rising edge
module vps_host_model (
  input  wire logic        sys_clk,
  input  wire logic        update_pending,
  input  wire logic [31:0] param_rdata,
  output logic             param_write,
  output logic      [4:0]  param_addr,
  output logic      [31:0] param_wdata,
  output logic             frame_start
);
  // Quiet bus at time zero
  initial begin
    param_write = 1'b0;
    param_addr  = 5'h00;
    param_wdata = 32'h00000000;
    frame_start = 1'b0;
  end

  // One-cycle write; waits for free shadows unless a refusal is wanted
  task automatic write_reg(input logic [4:0] a, input logic [31:0] d, input bit push);
    int n;
    n = 0;
    while (!push && update_pending !== 1'b0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    param_write <= 1'b1;
    param_addr  <= a;
    param_wdata <= d;
    @(posedge sys_clk);
    param_write <= 1'b0;
    param_wdata <= ~d; // Released data does not keep its last value
  endtask

  // Read data is registered, so it is taken two edges after the address
  task automatic read_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    param_addr <= a;
    @(posedge sys_clk);
    @(posedge sys_clk);
    #1 d = param_rdata;
  endtask

  // One-cycle frame start, then one edge for the working copies to settle
  task automatic frame_pulse();
    @(posedge sys_clk);
    frame_start <= 1'b1;
    @(posedge sys_clk);
    frame_start <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
endmodule // vps_host_model
`default_nettype wire

// [dv/tb_video_param_shadow_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_video_param_shadow_regs;
  logic        sys_clk;
  logic        reset_n;
  logic        param_write;
  logic [4:0]  param_addr;
  logic [31:0] param_wdata;
  logic [31:0] param_rdata;
  logic        frame_start;
  logic [15:0] work_width_m1;
  logic [15:0] work_height_m1;
  logic        work_first_field;
  logic        work_bypass;
  logic        work_keep;
  logic [15:0] work_still_th;
  logic [15:0] work_slow_th;
  logic        repeat_frame;
  logic        suppress_frames;
  logic        update_pending;
  logic [15:0] bursts_per_line;
  logic        burst_fits_line;
  logic [2:0]  frame_spaces;
  int          n_mismatch;
  int          n_tests;
  logic [31:0] rd;

  // Expected burst counts and memory rate multiple, from the generation constants
  localparam int LINE_BURSTS_MAX = vps_pkg::MAX_WIDTH * vps_pkg::PIX_BITS / vps_pkg::BURST_BITS;
  localparam int LINE_BURSTS_640 = 640 * vps_pkg::PIX_BITS / vps_pkg::BURST_BITS;
  localparam int BW_NEED = vps_pkg::INTER_ALGO ? (vps_pkg::FRC_EN ? 5 : 3)
                                               : (vps_pkg::FRC_EN ? 3 : 2);

  vps_regs i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .param_write(param_write),
    .param_addr(param_addr), .param_wdata(param_wdata), .param_rdata(param_rdata),
    .frame_start(frame_start), .work_width_m1(work_width_m1),
    .work_height_m1(work_height_m1), .work_first_field(work_first_field),
    .work_bypass(work_bypass), .work_keep(work_keep), .work_still_th(work_still_th),
    .work_slow_th(work_slow_th), .repeat_frame(repeat_frame),
    .suppress_frames(suppress_frames), .update_pending(update_pending),
    .bursts_per_line(bursts_per_line), .burst_fits_line(burst_fits_line),
    .frame_spaces(frame_spaces));

  vps_host_model i_host (.sys_clk(sys_clk), .update_pending(update_pending),
    .param_rdata(param_rdata), .param_write(param_write), .param_addr(param_addr),
    .param_wdata(param_wdata), .frame_start(frame_start));

  // 25 MHz clock
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  // Compare one value and count it
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Read one register and compare it
  task automatic check_rd(input logic [4:0] a, input logic [31:0] exp);
    i_host.read_reg(a, rd);
    check($sformatf("rdata at %h", a), exp, rd);
  endtask

  // Defaults after reset, read back and on the working outputs
  task automatic t_reset();
    logic [31:0] exp [8];
    exp = '{32'(vps_pkg::RST_WIDTH), 32'(vps_pkg::RST_HEIGHT), 32'(vps_pkg::RST_FIELD),
            32'h0, 32'h0, 32'(vps_pkg::RST_STILL_TH), 32'(vps_pkg::RST_SLOW_TH), 32'h0};
    for (int i = 0; i < 8; i++) check_rd(5'(i * 4), exp[i]);
    check_rd(5'h1e, 32'h0);
    check("work width", 32'd1919, 32'(work_width_m1));
    check("work height", 32'd1079, 32'(work_height_m1));
    check("work bypass", 32'h0, 32'(work_bypass));
    check("work keep", 32'h0, 32'(work_keep));
    check("frame spaces", 32'd3, 32'(frame_spaces));
    check("bursts", 32'(LINE_BURSTS_MAX), 32'(bursts_per_line));
    check("mem rate", 32'd3, 32'(BW_NEED));
  endtask

  // Shadow writes leave size settings alone; keep and thresholds follow any frame
  task automatic t_shadow();
    i_host.write_reg(5'h00, 32'd639, 1'b0);
    i_host.write_reg(5'h04, 32'd479, 1'b0);
    i_host.write_reg(5'h08, 32'h1, 1'b0);
    i_host.write_reg(5'h0c, 32'h1, 1'b0);
    i_host.write_reg(5'h10, 32'h1, 1'b0);
    i_host.write_reg(5'h14, 32'h20, 1'b0);
    i_host.write_reg(5'h18, 32'h40, 1'b0);
    i_host.write_reg(5'h1e, 32'h55, 1'b0);
    check_rd(5'h00, 32'd639);
    check_rd(5'h18, 32'h40);
    check_rd(5'h1e, 32'h0);
    check("work width", 32'd1919, 32'(work_width_m1));
    i_host.frame_pulse();
    check("work width", 32'd1919, 32'(work_width_m1));
    check("work bypass", 32'h0, 32'(work_bypass));
    check("work keep", 32'h1, 32'(work_keep));
    check("work still", 32'h20, 32'(work_still_th));
    check("work slow", 32'h40, 32'(work_slow_th));
    check("suppress", 32'h1, 32'(suppress_frames));
    check("repeat", 32'h0, 32'(repeat_frame));
  endtask

  // Commit on frame start, with a refused write while the flag is set
  task automatic t_commit();
    i_host.write_reg(5'h1c, 32'h1, 1'b0);
    check_rd(5'h1c, 32'h1);
    i_host.write_reg(5'h00, 32'd99, 1'b1);
    check_rd(5'h00, 32'd639);
    i_host.frame_pulse();
    check("work width", 32'd639, 32'(work_width_m1));
    check("work height", 32'd479, 32'(work_height_m1));
    check("work field", 32'h1, 32'(work_first_field));
    check("work bypass", 32'h1, 32'(work_bypass));
    check("update", 32'h0, 32'(update_pending));
    check("burst fits", 32'h1, 32'(burst_fits_line));
    check("several bursts", 32'h1, 32'(bursts_per_line > 16'h0001));
    check("bursts", 32'(LINE_BURSTS_640), 32'(bursts_per_line));
    // Second commit turns field, bypass and keep back off
    i_host.write_reg(5'h08, 32'h0, 1'b0);
    i_host.write_reg(5'h0c, 32'h0, 1'b0);
    i_host.write_reg(5'h10, 32'h0, 1'b0);
    i_host.write_reg(5'h1c, 32'h1, 1'b0);
    i_host.frame_pulse();
    check("work field", 32'h0, 32'(work_first_field));
    check("work bypass", 32'h0, 32'(work_bypass));
    check("suppress", 32'h0, 32'(suppress_frames));
    check_rd(5'h1c, 32'h0);
  endtask

  // Reset in mid-run drops a pending commit and restores every default
  task automatic t_mid_reset();
    i_host.write_reg(5'h0c, 32'h1, 1'b0);
    i_host.write_reg(5'h1c, 32'h1, 1'b0);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    check_rd(5'h1c, 32'h0);
    check_rd(5'h0c, 32'h0);
    check("update", 32'h0, 32'(update_pending));
    check("work width", 32'(vps_pkg::RST_WIDTH), 32'(work_width_m1));
    check("work still", 32'(vps_pkg::RST_STILL_TH), 32'(work_still_th));
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_shadow();
    t_commit();
    t_mid_reset();
    report_and_stop();
  end
endmodule // tb_video_param_shadow_regs
`default_nettype wire
